// *** core/mdd_flags.sv ***
// Sticky digital diagnostic error flags with frame checking
`timescale 1ns/10ps
module mdd_flags
  import mdd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire mdd_frame_t i_frame,
  input wire logic i_cal_not_ready,
  input wire logic i_interdie_rc_en,
  input wire logic i_interdie_parity_err,
  input wire logic [15:0] i_latch_in,
  input wire logic [15:0] i_latch_out,
  input wire logic [15:0] i_core_code,
  input wire logic i_cal_start,
  input wire logic i_cal_valid,
  input wire logic [7:0] i_cal_byte,
  input wire logic i_cal_end,
  input wire logic [7:0] i_cal_crc,
  input wire logic [9:0] i_diag_en,
  input wire logic [5:0] i_upper_flags,
  output logic [23:0] o_read_word,
  output mdd_commit_t o_commit
);

  typedef struct packed {
    logic [9:0] flags;
    logic [4:0] addr_echo;
    logic [15:0] code;
    logic [15:0] code_inv;
    logic [7:0] cal_acc;
    logic [23:0] read_word;
    mdd_commit_t commit;
  } mdd_state_t;

  localparam mdd_state_t ST_RST = '{
    flags: FLAGS_RST,
    addr_echo: ECHO_RST,
    code: 16'h0000,
    code_inv: 16'hFFFF,
    cal_acc: CRC_SEED,
    read_word: RESULTS_RST,
    commit: '0
  };

  mdd_state_t st_q;
  mdd_state_t st_d;

  logic [7:0] crc_chain [CRC_BYTES+1];
  logic [7:0] cal_next;
  logic is_long;
  logic is_short;
  logic count_err;
  logic slip_err;
  logic crc_err;
  logic frame_bad;
  logic frame_good;
  logic [23:0] word;
  logic rd;
  logic [4:0] addr;
  logic access_err;
  logic commit_ok;
  logic [9:0] set_v;
  logic [9:0] clr_v;

  // Frame CRC runs over the 24 payload bits of a 32-edge frame
  assign crc_chain[0] = CRC_SEED;
  generate
    for (genvar k = 0; k < CRC_BYTES; k++) begin : g_crc
      mdd_crc8_step u_step (
        .i_seed(crc_chain[k]),
        .i_byte(i_frame.bits[31-8*k -: 8]),
        .o_crc(crc_chain[k+1])
      );
    end
  endgenerate

  mdd_crc8_step u_cal_step (
    .i_seed(st_q.cal_acc),
    .i_byte(i_cal_byte),
    .o_crc(cal_next)
  );

  assign is_long = (i_frame.edges == EDGES_LONG);
  assign is_short = (i_frame.edges == EDGES_SHORT);
  assign count_err = i_frame.crc_en ? !is_long : !(is_long || is_short);
  assign word = is_long ? i_frame.bits[31:8] : i_frame.bits[23:0];
  // A miscounted frame has no trustworthy layout, so only its count is judged
  assign slip_err = !count_err && (word[FRM_SLIP] == word[FRM_RD]);
  assign crc_err = !count_err && i_frame.crc_en &&
                   (crc_chain[CRC_BYTES] != i_frame.bits[7:0]);
  assign frame_bad = count_err || slip_err || crc_err;
  assign frame_good = i_frame.end_p && !frame_bad;
  assign rd = word[FRM_RD];
  assign addr = word[FRM_ADDR_HI:FRM_ADDR_LO];
  assign access_err = frame_good && (!mdd_addr_valid(addr) ||
                      (!rd && mdd_addr_ro(addr)) ||
                      (!rd && i_cal_not_ready && addr != ADDR_RB_SEL));
  assign commit_ok = frame_good && !access_err;

  always_comb begin
    set_v = '0;
    set_v[BIT_INTERDIE] = i_interdie_rc_en && i_interdie_parity_err;
    set_v[BIT_LATCH] = (i_latch_in != i_latch_out);
    set_v[BIT_INVERSE] = (st_q.code != ~st_q.code_inv);
    set_v[BIT_CAL_CRC] = i_cal_end && (st_q.cal_acc != i_cal_crc);
    set_v[BIT_ACCESS] = access_err;
    set_v[BIT_COUNT] = i_frame.end_p && count_err;
    set_v[BIT_SLIP] = i_frame.end_p && slip_err;
    set_v[BIT_FRAME_CRC] = i_frame.end_p && crc_err;
    clr_v = '0;
    if (commit_ok && !rd && addr == ADDR_RESULTS) begin
      clr_v = word[9:0] & FLAG_IMPL;
    end
  end

  always_comb begin
    st_d = st_q;
    // Set wins over a clear in the same cycle so no event is lost
    st_d.flags = ((st_q.flags & ~clr_v) | set_v) & FLAG_IMPL;
    st_d.code = i_core_code;
    st_d.code_inv = ~i_core_code;
    if (i_cal_start) begin
      st_d.cal_acc = CRC_SEED;
    end else if (i_cal_valid) begin
      st_d.cal_acc = cal_next;
    end
    st_d.commit = '0;
    if (commit_ok) begin
      st_d.commit.valid = 1'b1;
      st_d.commit.write = !rd;
      st_d.commit.addr = addr;
      st_d.commit.data = word[15:0];
      st_d.addr_echo = addr;
    end
    st_d.read_word = {3'b000, st_q.addr_echo, i_upper_flags,
                      st_q.flags & i_diag_en & FLAG_IMPL};
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_read_word = st_q.read_word;
  assign o_commit = st_q.commit;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  interdie_flag_a: assert property (
    i_interdie_rc_en && i_interdie_parity_err |=> st_q.flags[9])
    else $error("interdie parity not flagged");

  latch_flag_a: assert property (
    i_latch_in != i_latch_out |=> st_q.flags[8])
    else $error("latch mismatch not flagged");

  cal_crc_flag_a: assert property (
    i_cal_end && st_q.cal_acc != i_cal_crc |=> st_q.flags[5])
    else $error("cal crc error not flagged");

  bad_addr_flag_a: assert property (
    frame_good && !mdd_addr_valid(addr) |=> st_q.flags[4] && !o_commit.valid)
    else $error("bad address not flagged");

  early_write_a: assert property (
    frame_good && !rd && i_cal_not_ready && addr != ADDR_RB_SEL
    |=> st_q.flags[4] && !o_commit.valid)
    else $error("write during refresh not flagged");

  readback_ok_a: assert property (
    frame_good && !rd && addr == ADDR_RB_SEL |=> o_commit.valid)
    else $error("readback select refused");

  ro_write_a: assert property (
    frame_good && !rd && mdd_addr_ro(addr) |=> st_q.flags[4])
    else $error("read-only write not flagged");

  count_flag_a: assert property (
    i_frame.end_p && i_frame.crc_en && i_frame.edges != EDGES_LONG
    |=> st_q.flags[2] && !o_commit.valid)
    else $error("edge count error not flagged");

  slip_flag_a: assert property (
    i_frame.end_p && is_short && !i_frame.crc_en &&
    i_frame.bits[23] == i_frame.bits[22] |=> st_q.flags[1])
    else $error("slip bit not flagged");

  frame_crc_a: assert property (
    i_frame.end_p && crc_err |=> st_q.flags[0] ##1 (o_read_word[0] ||
    !$past(i_diag_en[0])))
    else $error("frame crc not flagged");

  sticky_keep_a: assert property (
    st_q.flags[2] && !clr_v[2] |=> st_q.flags[2])
    else $error("flag lost without clear");

  w1c_clear_a: assert property (
    clr_v[4] && !set_v[4] |=> !st_q.flags[4])
    else $error("write one did not clear");

  mask_read_a: assert property (
    !i_diag_en[1] |=> !o_read_word[1])
    else $error("disabled flag reads nonzero");

  echo_addr_a: assert property (
    commit_ok |=> ##1 o_read_word[20:16] == $past(addr, 2))
    else $error("address echo wrong");

  discard_a: assert property (
    i_frame.end_p && frame_bad |=> !o_commit.valid)
    else $error("failing frame committed");

  good_write_c: cover property (commit_ok && !rd ##1 o_commit.valid);
  results_clear_c: cover property (clr_v != '0 ##1 st_q.flags == '0);
  count_err_c: cover property (i_frame.end_p && count_err);
  cal_crc_err_c: cover property (set_v[BIT_CAL_CRC]);

endmodule : mdd_flags

// *** core/mdd_pkg.sv ***
// Shared constants, carriers and decoders for the diagnostic error flags
package mdd_pkg;

  localparam int FLAG_W = 10;
  localparam int BIT_INTERDIE = 9;
  localparam int BIT_LATCH = 8;
  localparam int BIT_INVERSE = 6;
  localparam int BIT_CAL_CRC = 5;
  localparam int BIT_ACCESS = 4;
  localparam int BIT_COUNT = 2;
  localparam int BIT_SLIP = 1;
  localparam int BIT_FRAME_CRC = 0;
  // Bits 7 and 3 are reserved and read as zero
  localparam logic [9:0] FLAG_IMPL = 10'h377;
  localparam logic [9:0] FLAGS_RST = 10'h000;

  localparam logic [4:0] ADDR_RB_SEL = 5'h13;
  localparam logic [4:0] ADDR_RESULTS = 5'h14;
  localparam logic [23:0] RESULTS_RST = 24'h14A000;
  localparam logic [4:0] ECHO_RST = 5'h14;

  localparam logic [5:0] EDGES_SHORT = 6'h18;
  localparam logic [5:0] EDGES_LONG = 6'h20;
  localparam int FRM_SLIP = 23;
  localparam int FRM_RD = 22;
  localparam int FRM_ADDR_HI = 20;
  localparam int FRM_ADDR_LO = 16;
  localparam int CRC_BYTES = 3;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;

  typedef struct packed {
    logic end_p;
    logic crc_en;
    logic [5:0] edges;
    logic [31:0] bits;
  } mdd_frame_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] data;
  } mdd_commit_t;

  function automatic logic mdd_addr_valid(input logic [4:0] a);
    if (a == 5'h0D || a == 5'h0E) begin
      return 1'b0;
    end else if (a >= 5'h19 && a <= 5'h1B) begin
      return 1'b0;
    end else if (a > 5'h1C) begin
      return 1'b0;
    end else begin
      return 1'b1;
    end
  endfunction : mdd_addr_valid

  function automatic logic mdd_addr_ro(input logic [4:0] a);
    if (a >= 5'h16 && a <= 5'h18) begin
      return 1'b1;
    end else if (a == 5'h1C) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : mdd_addr_ro

endpackage : mdd_pkg

// *** core/mdd_crc8_step.sv ***
// One byte step of the CRC-8 used on frames and calibration memory
`timescale 1ns/10ps
module mdd_crc8_step
  import mdd_pkg::*;
(
  input wire logic [7:0] i_seed,
  input wire logic [7:0] i_byte,
  output logic [7:0] o_crc
);
  logic [7:0] c;
  logic fb;

  always_comb begin
    c = i_seed;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[7] ^ i_byte[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    o_crc = c;
  end
endmodule : mdd_crc8_step

// *** sim/mdd_host_model.sv ***
// Host serial controller model that frames requests for the flag block
`timescale 1ns/10ps
module mdd_host_model
  import mdd_pkg::*;
(
  input wire logic i_sys_clk,
  output mdd_frame_t o_frame
);
  initial o_frame = '0;

  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // Fault 1 breaks the slip pattern, fault 2 corrupts the CRC
  task automatic send(input logic rd, input logic [4:0] a,
      input logic [15:0] d, input logic [5:0] n, input logic ce,
      input logic [1:0] f);
    logic [23:0] w;
    w = {~rd, rd, 1'b0, a, d};
    if (f == 2'h1) w[23] = rd;
    @(negedge i_sys_clk);
    o_frame.end_p = 1'b1;
    o_frame.crc_en = ce;
    o_frame.edges = n;
    o_frame.bits = (n == EDGES_LONG) ?
        {w, crc8(w) ^ {7'h00, f == 2'h2}} : {8'h00, w};
    @(negedge i_sys_clk);
    o_frame.end_p = 1'b0;
    // Scrambled after the frame so stale bits cannot pass for new ones
    o_frame.bits = ~o_frame.bits;
  endtask : send
endmodule : mdd_host_model

// *** sim/digital_diag_error_flags_tb.sv ***
// Self-checking bench for the diagnostic error flag block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module digital_diag_error_flags_tb
  import mdd_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  mdd_frame_t frame;
  logic cal_nr, rc_en, par_err, cal_start, cal_valid, cal_end;
  logic [15:0] l_in, l_out, core;
  logic [7:0] cal_byte, cal_crc;
  logic [9:0] diag_en;
  logic [5:0] upper;
  logic [23:0] read_word;
  mdd_commit_t commit;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 i_sys_clk = ~i_sys_clk;

  mdd_host_model host (.i_sys_clk(i_sys_clk), .o_frame(frame));

  mdd_flags dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_frame(frame),
    .i_cal_not_ready(cal_nr), .i_interdie_rc_en(rc_en),
    .i_interdie_parity_err(par_err), .i_latch_in(l_in),
    .i_latch_out(l_out), .i_core_code(core), .i_cal_start(cal_start),
    .i_cal_valid(cal_valid), .i_cal_byte(cal_byte), .i_cal_end(cal_end),
    .i_cal_crc(cal_crc), .i_diag_en(diag_en), .i_upper_flags(upper),
    .o_read_word(read_word), .o_commit(commit));

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Checks the flags, then clears them all with a write-one
  task automatic flagchk(input logic [9:0] m);
    repeat (2) @(negedge i_sys_clk);
    `CHK("flags", m, read_word[9:0])
    cal_nr = 1'b0;
    host.send(1'b0, ADDR_RESULTS, 16'h03FF, EDGES_LONG, 1'b1, 2'h0);
    repeat (2) @(negedge i_sys_clk);
    `CHK("cleared", 10'h000, read_word[9:0])
  endtask : flagchk

  task automatic frm(input logic rd, input logic [4:0] a,
      input logic [5:0] n, input logic ce, input logic [1:0] f,
      input logic v, input logic [9:0] m);
    host.send(rd, a, 16'h5A3C, n, ce, f);
    `CHK("commit valid", v, commit.valid)
    flagchk(m);
  endtask : frm

  task automatic cal(input logic [7:0] crc);
    cal_start = 1'b1;
    @(negedge i_sys_clk);
    cal_start = 1'b0;
    cal_valid = 1'b1;
    cal_byte = 8'h01;
    @(negedge i_sys_clk);
    cal_valid = 1'b0;
    cal_end = 1'b1;
    cal_crc = crc;
    @(negedge i_sys_clk);
    cal_end = 1'b0;
  endtask : cal

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {cal_nr, rc_en, par_err, cal_start, cal_valid, cal_end} = '0;
    {l_in, l_out, cal_byte, cal_crc} = '0;
    // Upper bits carry the unrefreshed and reset-seen flags from elsewhere
    upper = 6'h28;
    core = 16'h1234;
    diag_en = 10'h3FF;
    repeat (8) @(negedge i_sys_clk);
    `CHK("reset word", 24'h14A000, read_word)
    i_rst = 1'b0;
    @(negedge i_sys_clk);
    `CHK("word", 24'h14A000, read_word)
    host.send(1'b0, 5'h05, 16'hA5C3, EDGES_LONG, 1'b1, 2'h0);
    `CHK("commit", {1'b1, 1'b1, 5'h05, 16'hA5C3}, commit)
    frm(1'b1, ADDR_RESULTS, EDGES_SHORT, 1'b0, 2'h0, 1'b1, 10'h000);
    frm(1'b0, 5'h05, EDGES_LONG, 1'b0, 2'h0, 1'b1, 10'h000);
    frm(1'b0, 5'h05, EDGES_SHORT, 1'b1, 2'h0, 1'b0, 10'h004);
    frm(1'b0, 5'h05, 6'h19, 1'b0, 2'h0, 1'b0, 10'h004);
    frm(1'b0, 5'h05, EDGES_LONG, 1'b1, 2'h1, 1'b0, 10'h002);
    frm(1'b0, 5'h05, EDGES_SHORT, 1'b0, 2'h1, 1'b0, 10'h002);
    frm(1'b0, 5'h05, EDGES_LONG, 1'b1, 2'h2, 1'b0, 10'h001);
    frm(1'b1, 5'h0D, EDGES_LONG, 1'b1, 2'h0, 1'b0, 10'h010);
    frm(1'b0, 5'h1B, EDGES_SHORT, 1'b0, 2'h0, 1'b0, 10'h010);
    frm(1'b0, 5'h16, EDGES_LONG, 1'b1, 2'h0, 1'b0, 10'h010);
    cal_nr = 1'b1;
    frm(1'b1, 5'h05, EDGES_LONG, 1'b1, 2'h0, 1'b1, 10'h000);
    cal_nr = 1'b1;
    frm(1'b0, ADDR_RB_SEL, EDGES_LONG, 1'b1, 2'h0, 1'b1, 10'h000);
    cal_nr = 1'b1;
    frm(1'b0, 5'h05, EDGES_LONG, 1'b1, 2'h0, 1'b0, 10'h010);
    host.send(1'b0, 5'h05, 16'h0, EDGES_LONG, 1'b1, 2'h1);
    host.send(1'b0, ADDR_RESULTS, 16'h0001, EDGES_LONG, 1'b1, 2'h0);
    flagchk(10'h002);
    host.send(1'b0, 5'h05, 16'h0, EDGES_LONG, 1'b1, 2'h1);
    diag_en = 10'h3FD;
    repeat (2) @(negedge i_sys_clk);
    `CHK("masked", 10'h000, read_word[9:0])
    diag_en = 10'h3FF;
    flagchk(10'h002);
    par_err = 1'b1;
    @(negedge i_sys_clk);
    par_err = 1'b0;
    flagchk(10'h000);
    rc_en = 1'b1;
    par_err = 1'b1;
    @(negedge i_sys_clk);
    par_err = 1'b0;
    flagchk(10'h200);
    core = 16'hEDCB;
    l_in = 16'h0001;
    @(negedge i_sys_clk);
    l_out = 16'h0001;
    flagchk(10'h100);
    cal(8'h07);
    flagchk(10'h000);
    cal(8'h08);
    flagchk(10'h020);
    conclude();
  end
endmodule : digital_diag_error_flags_tb
